// ===== cssi_checker.sv
// Purpose: Port checks of the setpoint block
// Assumes: Interpolation cycle of at least 9 core clocks
// Notes: Bound to every cssi_top instance
`timescale 1ns/1ps
`default_nettype none
module cssi_checker
    import cssi_pkg::*;
(
    input wire logic CORE_CLK_IN,
    input wire logic NRST_IN,
    input wire cssi_od_req_t OD_REQ_IN,
    input wire logic OD_ACK_OUT,
    input wire logic OD_ERR_OUT,
    input wire logic CLOSED_LOOP_IN,
    input wire logic CYCLE_TICK_OUT,
    input wire logic [31:0] DEMAND_POS_OUT,
    input wire logic [ANGLE_W-1:0] ELEC_ANGLE_OUT,
    input wire logic [15:0] STATUS_OUT
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!NRST_IN);
    // Object bus answers each request once
    a_ack_after_req: assert property ((OD_REQ_IN.wr || OD_REQ_IN.rd) |=> OD_ACK_OUT)
        else $error("no ack");
    a_ack_only_req: assert property (OD_ACK_OUT |-> $past(OD_REQ_IN.wr || OD_REQ_IN.rd))
        else $error("stray ack");
    a_err_with_ack: assert property (OD_ERR_OUT |-> OD_ACK_OUT)
        else $error("err without ack");
    // Status word, step and tick outputs
    a_status_rsvd: assert property ((STATUS_OUT & 16'hCEFF) == 16'h0000)
        else $error("reserved status bit");
    a_angle_follow: assert property (ELEC_ANGLE_OUT == $past(DEMAND_POS_OUT[ANGLE_W-1:0]))
        else $error("angle off");
    a_ferr_closed: assert property (STATUS_OUT[SW_FERR_BIT] |-> $past(CLOSED_LOOP_IN, 2))
        else $error("ferr open loop");
    a_tick_spacing: assert property (CYCLE_TICK_OUT |=> !CYCLE_TICK_OUT [*8])
        else $error("tick spacing");
    // Sync bit moves one edge after a tick, or two edges after a mode write
    a_sync_at_tick: assert property ($changed(STATUS_OUT[SW_SYNC_BIT])
        |-> $past(CYCLE_TICK_OUT) || $past(OD_REQ_IN.wr, 2))
        else $error("sync bit off tick");
endmodule
bind cssi_top cssi_checker cssi_checker_inst (.CORE_CLK_IN, .NRST_IN, .OD_REQ_IN,
    .OD_ACK_OUT, .OD_ERR_OUT, .CLOSED_LOOP_IN, .CYCLE_TICK_OUT, .DEMAND_POS_OUT,
    .ELEC_ANGLE_OUT, .STATUS_OUT);
`default_nettype wire

// ===== cssi_pkg.sv
// Purpose: Shared constants and types of the cyclic setpoint and step input block
// Assumes: 50 MHz core clock, object access by index and subindex
// Notes: Object indexes are the dictionary indexes of the drive
package cssi_pkg;

    // Object indexes and subindexes
    localparam logic [15:0] IDX_STEP_NUM = 16'h2057;
    localparam logic [15:0] IDX_STEP_DEN = 16'h2058;
    localparam logic [15:0] IDX_STATUS = 16'h6041;
    localparam logic [15:0] IDX_MODE = 16'h6060;
    localparam logic [15:0] IDX_FE_WINDOW = 16'h6065;
    localparam logic [15:0] IDX_FE_TIMEOUT = 16'h6066;
    localparam logic [15:0] IDX_TGT_TORQUE = 16'h6071;
    localparam logic [15:0] IDX_MAX_TORQUE = 16'h6072;
    localparam logic [15:0] IDX_MAX_CURRENT = 16'h6073;
    localparam logic [15:0] IDX_CYCLE = 16'h60C2;
    localparam logic [15:0] IDX_TGT_VEL = 16'h60FF;
    localparam logic [7:0] SUB_PERIOD = 8'h01;
    localparam logic [7:0] SUB_TIME_INDEX = 8'h02;

    // Mode selection and time index codes
    localparam logic [7:0] MODE_CODE_CSV = 8'h09;
    localparam logic [7:0] MODE_CODE_CST = 8'h0A;
    localparam logic [7:0] MODE_CODE_CLKDIR = 8'hFF;
    localparam logic [7:0] TIME_INDEX_MS = 8'hFD;

    // Reset values
    localparam logic [31:0] RST_STEP_NUM = 32'h0000_0080;
    localparam logic [31:0] RST_STEP_DEN = 32'h0000_0001;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'h01;
    localparam logic [15:0] RST_MAX_TORQUE = 16'h03E8;
    localparam logic [15:0] RST_MAX_CURRENT = 16'h03E8;
    localparam logic [31:0] RST_FE_WINDOW = 32'h0000_0400;
    localparam logic [15:0] RST_FE_TIMEOUT = 16'h000A;

    // Status word bit positions
    localparam int SW_SYNC_BIT = 8;
    localparam int SW_FOLLOW_BIT = 12;
    localparam int SW_FERR_BIT = 13;

    // Step geometry: 512 per full step, four full steps per pole pair
    localparam int FULL_STEP_UNITS = 512;
    localparam int STEPS_PER_POLE_PAIR = 4;
    localparam int ANGLE_W = $clog2(FULL_STEP_UNITS * STEPS_PER_POLE_PAIR);

    // Direction level that selects positive counting
    localparam logic DIR_POS_LEVEL = 1'b1;

    // Time base of one millisecond
    localparam int CLK_PERIOD_NS = 20;
    localparam int TIME_BASE_US = 1000;
    localparam int MS_TICK_CLKS = TIME_BASE_US * 1000 / CLK_PERIOD_NS;

    // Serial divider length
    localparam int DIV_STEPS = 64;

    typedef enum {
        CSSI_MODE_OTHER,
        CSSI_MODE_CSV,
        CSSI_MODE_CST,
        CSSI_MODE_CLKDIR
    } cssi_mode_t;

    typedef enum {
        CSSI_DIV_IDLE,
        CSSI_DIV_RUN
    } cssi_div_state_t;

    // Object access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] wdata;
    } cssi_od_req_t;

endpackage

// ===== cssi_pulse_src.sv
// Purpose: Pulse source model driving clock and direction pins
// Assumes: Called from the bench through send
// Notes: Clock idles low between bursts
`timescale 1ns/1ps
`default_nettype none
module cssi_pulse_src (
    output logic clk_out,
    output logic dir_out
);
    // Idle state
    initial begin
        clk_out = 1'b0;
        dir_out = 1'b1;
    end
    // Burst of n pulses in direction d
    task automatic send(input int n, input logic d);
        if (d !== dir_out) begin
            dir_out = d;
            #35000;
        end
        repeat (n) begin
            clk_out = 1'b1;
            #200;
            clk_out = 1'b0;
            #800;
        end
    endtask
endmodule
`default_nettype wire

// ===== cssi_step_sync.sv
// Purpose: Brings the clock and direction pins into the core clock domain
// Assumes: Pins are asynchronous to the core clock
// Notes: A level counts once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module cssi_step_sync (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic clk_pin_in,
    input wire logic dir_pin_in,
    output logic step_out,
    output logic dir_out
);
    logic [2:0] clk_sync;
    logic [2:0] dir_sync;
    logic clk_level;

    // Three stage synchronisers
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            clk_sync <= 3'h0;
            dir_sync <= 3'h0;
        end else begin
            clk_sync <= {clk_sync[1:0], clk_pin_in};
            dir_sync <= {dir_sync[1:0], dir_pin_in};
        end
    end

    // Accepted levels and rising edge of the clock pin
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            clk_level <= 1'b0;
            dir_out <= 1'b0;
            step_out <= 1'b0;
        end else begin
            step_out <= 1'b0;
            if (clk_sync[1] == clk_sync[2]) begin
                clk_level <= clk_sync[2];
                step_out <= clk_sync[2] & ~clk_level;
            end
            if (dir_sync[1] == dir_sync[2]) begin
                dir_out <= dir_sync[2];
            end
        end
    end
endmodule
`default_nettype wire

// ===== cssi_top.sv
// Purpose: Setpoint front end for cyclic velocity, torque and step input
// Assumes: Object access is one request per cycle, answered one cycle later
// Notes: Position demand keeps the fraction of the step scaling exactly
`timescale 1ns/1ps
`default_nettype none
module cssi_top
    import cssi_pkg::*;
#(
    parameter int MS_CLKS = MS_TICK_CLKS
) (
    input wire logic CORE_CLK_IN,
    input wire logic NRST_IN,
    input wire cssi_od_req_t OD_REQ_IN,
    output logic [31:0] OD_RDATA_OUT,
    output logic OD_ACK_OUT,
    output logic OD_ERR_OUT,
    input wire logic STEP_CLK_IN,
    input wire logic STEP_DIR_IN,
    input wire logic FIELDBUS_SYNC_IN,
    input wire logic CLOSED_LOOP_IN,
    input wire logic OP_ENABLED_IN,
    input wire logic [31:0] ACTUAL_POS_IN,
    output logic CYCLE_TICK_OUT,
    output logic [31:0] VEL_CMD_OUT,
    output logic [15:0] TORQUE_CMD_OUT,
    output logic [31:0] DEMAND_POS_OUT,
    output logic [ANGLE_W-1:0] ELEC_ANGLE_OUT,
    output logic [15:0] STATUS_OUT
);
    // Object store
    logic [31:0] step_num;
    logic [31:0] step_den;
    logic [7:0] mode_code;
    logic [7:0] period_ms;
    logic [7:0] time_index;
    logic [31:0] tgt_vel;
    logic [15:0] tgt_torque;
    logic [15:0] max_torque;
    logic [15:0] max_current;
    logic [31:0] fe_window;
    logic [15:0] fe_timeout;

    // Timing
    logic [15:0] ms_cnt;
    logic ms_tick;
    logic [7:0] cyc_cnt;
    logic cyc_tick;

    // Status
    cssi_mode_t mode;
    logic in_sync;
    logic sync_seen;
    logic follow;
    logic ferr;
    logic [15:0] fe_cnt;

    // Step path
    logic step_pulse;
    logic step_dir;
    logic signed [19:0] pulse_acc;
    logic signed [19:0] next_pulse_acc;
    logic signed [63:0] pos_total;
    logic signed [63:0] step_prod;

    // Divider
    cssi_div_state_t div_state;
    logic div_start;
    logic [6:0] div_cnt;
    logic [63:0] div_dvd;
    logic [32:0] div_rem;
    logic [31:0] div_den;
    logic div_neg;
    logic [32:0] rem_shift;

    // Torque limit and position error
    logic [15:0] torque_lim;
    logic signed [16:0] torque_clamped;
    logic signed [32:0] pos_err;

    // Smaller of two unsigned 16 bit limits
    function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
        min16 = (a < b) ? a : b;
    endfunction

    // Magnitude of a signed value
    function automatic logic [63:0] mag64(input logic signed [63:0] v);
        mag64 = v[63] ? 64'(-v) : 64'(v);
    endfunction

    // Object hit test
    function automatic logic hit(input cssi_od_req_t r, input logic [15:0] idx);
        hit = (r.index == idx);
    endfunction

    cssi_step_sync u_step_sync (
        .clk_in(CORE_CLK_IN),
        .nrst_in(NRST_IN),
        .clk_pin_in(STEP_CLK_IN),
        .dir_pin_in(STEP_DIR_IN),
        .step_out(step_pulse),
        .dir_out(step_dir)
    );

    // Mode decode; the control word plays no part here
    always_comb begin
        case (mode_code)
            MODE_CODE_CSV: mode = CSSI_MODE_CSV;
            MODE_CODE_CST: mode = CSSI_MODE_CST;
            MODE_CODE_CLKDIR: mode = CSSI_MODE_CLKDIR;
            default: mode = CSSI_MODE_OTHER;
        endcase
    end

    // Object writes
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            step_num <= RST_STEP_NUM;
            step_den <= RST_STEP_DEN;
            mode_code <= RST_MODE;
            period_ms <= RST_PERIOD;
            time_index <= TIME_INDEX_MS;
            tgt_vel <= 32'h0;
            tgt_torque <= 16'h0;
            max_torque <= RST_MAX_TORQUE;
            max_current <= RST_MAX_CURRENT;
            fe_window <= RST_FE_WINDOW;
            fe_timeout <= RST_FE_TIMEOUT;
        end else if (OD_REQ_IN.wr) begin
            if (hit(OD_REQ_IN, IDX_STEP_NUM)) begin
                step_num <= OD_REQ_IN.wdata;
            end
            if (hit(OD_REQ_IN, IDX_STEP_DEN) && OD_REQ_IN.wdata != 32'h0) begin
                step_den <= OD_REQ_IN.wdata;
            end
            if (hit(OD_REQ_IN, IDX_MODE)) begin
                mode_code <= OD_REQ_IN.wdata[7:0];
            end
            if (hit(OD_REQ_IN, IDX_CYCLE) && OD_REQ_IN.sub == SUB_PERIOD) begin
                period_ms <= OD_REQ_IN.wdata[7:0];
            end
            if (hit(OD_REQ_IN, IDX_CYCLE) && OD_REQ_IN.sub == SUB_TIME_INDEX
                && OD_REQ_IN.wdata[7:0] == TIME_INDEX_MS) begin
                time_index <= OD_REQ_IN.wdata[7:0];
            end
            if (hit(OD_REQ_IN, IDX_TGT_VEL)) begin
                tgt_vel <= OD_REQ_IN.wdata;
            end
            if (hit(OD_REQ_IN, IDX_TGT_TORQUE)) begin
                tgt_torque <= OD_REQ_IN.wdata[15:0];
            end
            if (hit(OD_REQ_IN, IDX_MAX_TORQUE)) begin
                max_torque <= OD_REQ_IN.wdata[15:0];
            end
            if (hit(OD_REQ_IN, IDX_MAX_CURRENT)) begin
                max_current <= OD_REQ_IN.wdata[15:0];
            end
            if (hit(OD_REQ_IN, IDX_FE_WINDOW)) begin
                fe_window <= OD_REQ_IN.wdata;
            end
            if (hit(OD_REQ_IN, IDX_FE_TIMEOUT)) begin
                fe_timeout <= OD_REQ_IN.wdata[15:0];
            end
        end
    end

    // Object answers: one cycle after the request
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            OD_ACK_OUT <= 1'b0;
            OD_ERR_OUT <= 1'b0;
            OD_RDATA_OUT <= 32'h0;
        end else begin
            OD_ACK_OUT <= OD_REQ_IN.wr | OD_REQ_IN.rd;
            OD_ERR_OUT <= 1'b0;
            OD_RDATA_OUT <= 32'h0;
            if (OD_REQ_IN.rd) begin
                case (OD_REQ_IN.index)
                    IDX_STEP_NUM: OD_RDATA_OUT <= step_num;
                    IDX_STEP_DEN: OD_RDATA_OUT <= step_den;
                    IDX_STATUS: OD_RDATA_OUT <= {16'h0, STATUS_OUT};
                    IDX_MODE: OD_RDATA_OUT <= {24'h0, mode_code};
                    IDX_FE_WINDOW: OD_RDATA_OUT <= fe_window;
                    IDX_FE_TIMEOUT: OD_RDATA_OUT <= {16'h0, fe_timeout};
                    IDX_TGT_TORQUE: OD_RDATA_OUT <= {16'h0, tgt_torque};
                    IDX_MAX_TORQUE: OD_RDATA_OUT <= {16'h0, max_torque};
                    IDX_MAX_CURRENT: OD_RDATA_OUT <= {16'h0, max_current};
                    IDX_TGT_VEL: OD_RDATA_OUT <= tgt_vel;
                    IDX_CYCLE: begin
                        if (OD_REQ_IN.sub == SUB_PERIOD) begin
                            OD_RDATA_OUT <= {24'h0, period_ms};
                        end else if (OD_REQ_IN.sub == SUB_TIME_INDEX) begin
                            OD_RDATA_OUT <= {24'h0, time_index};
                        end else begin
                            OD_ERR_OUT <= 1'b1;
                        end
                    end
                    default: OD_ERR_OUT <= 1'b1;
                endcase
            end else if (OD_REQ_IN.wr) begin
                case (OD_REQ_IN.index)
                    IDX_STATUS: OD_ERR_OUT <= 1'b1;
                    IDX_STEP_DEN: OD_ERR_OUT <= (OD_REQ_IN.wdata == 32'h0);
                    IDX_CYCLE: begin
                        if (OD_REQ_IN.sub == SUB_TIME_INDEX) begin
                            OD_ERR_OUT <= (OD_REQ_IN.wdata[7:0] != TIME_INDEX_MS);
                        end else begin
                            OD_ERR_OUT <= (OD_REQ_IN.sub != SUB_PERIOD);
                        end
                    end
                    IDX_STEP_NUM, IDX_MODE, IDX_FE_WINDOW, IDX_FE_TIMEOUT,
                    IDX_TGT_TORQUE, IDX_MAX_TORQUE, IDX_MAX_CURRENT,
                    IDX_TGT_VEL: OD_ERR_OUT <= 1'b0;
                    default: OD_ERR_OUT <= 1'b1;
                endcase
            end
        end
    end

    // Millisecond base from the core clock
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            ms_cnt <= 16'h0;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= (ms_cnt == 16'(MS_CLKS - 1));
            ms_cnt <= (ms_cnt == 16'(MS_CLKS - 1)) ? 16'h0 : ms_cnt + 16'h1;
        end
    end

    // Interpolation cycle: period value in milliseconds
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            cyc_cnt <= 8'h0;
            cyc_tick <= 1'b0;
        end else begin
            cyc_tick <= 1'b0;
            if (ms_tick) begin
                if (cyc_cnt + 8'h1 >= period_ms) begin
                    cyc_cnt <= 8'h0;
                    cyc_tick <= 1'b1;
                end else begin
                    cyc_cnt <= cyc_cnt + 8'h1;
                end
            end
        end
    end

    // Fieldbus sync: a sync event must arrive in each cycle
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            sync_seen <= 1'b0;
            in_sync <= 1'b0;
        end else if (cyc_tick) begin
            in_sync <= sync_seen | FIELDBUS_SYNC_IN;
            sync_seen <= 1'b0;
        end else if (FIELDBUS_SYNC_IN) begin
            sync_seen <= 1'b1;
        end
    end

    // Setpoint followed only when enabled; torque needs closed loop
    always_comb begin
        follow = OP_ENABLED_IN
            && (mode == CSSI_MODE_CSV || (mode == CSSI_MODE_CST && CLOSED_LOOP_IN));
        torque_lim = min16(max_torque, max_current);
        if (torque_lim > 16'h7FFF) begin
            torque_lim = 16'h7FFF;
        end
        if ($signed({tgt_torque[15], tgt_torque}) > $signed({1'b0, torque_lim})) begin
            torque_clamped = $signed({1'b0, torque_lim});
        end else if ($signed({tgt_torque[15], tgt_torque}) < -$signed({1'b0, torque_lim})) begin
            torque_clamped = -$signed({1'b0, torque_lim});
        end else begin
            torque_clamped = $signed({tgt_torque[15], tgt_torque});
        end
    end

    // Cyclic setpoints taken once per cycle
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            VEL_CMD_OUT <= 32'h0;
            TORQUE_CMD_OUT <= 16'h0;
            CYCLE_TICK_OUT <= 1'b0;
        end else begin
            CYCLE_TICK_OUT <= cyc_tick;
            if (cyc_tick) begin
                VEL_CMD_OUT <= (follow && mode == CSSI_MODE_CSV) ? tgt_vel : 32'h0;
                TORQUE_CMD_OUT <= (follow && mode == CSSI_MODE_CST)
                    ? torque_clamped[15:0] : 16'h0;
            end
        end
    end

    // Pulse accumulator: a pulse in the transfer cycle opens the new count
    always_comb begin
        next_pulse_acc = cyc_tick ? 20'sh0 : pulse_acc;
        if (step_pulse && mode == CSSI_MODE_CLKDIR) begin
            if (step_dir == DIR_POS_LEVEL) begin
                next_pulse_acc = next_pulse_acc + 20'sh1;
            end else begin
                next_pulse_acc = next_pulse_acc - 20'sh1;
            end
        end
        step_prod = 64'(pulse_acc) * $signed({32'h0, step_num});
    end

    // Per cycle transfer into the scaled position total
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            pulse_acc <= 20'sh0;
            pos_total <= 64'sh0;
            div_start <= 1'b0;
        end else begin
            pulse_acc <= next_pulse_acc;
            div_start <= cyc_tick;
            if (cyc_tick) begin
                pos_total <= pos_total + step_prod;
            end
        end
    end

    // Serial divide of the total by the denominator
    assign rem_shift = {div_rem[31:0], div_dvd[63]};

    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            div_state <= CSSI_DIV_IDLE;
            div_cnt <= 7'h0;
            div_dvd <= 64'h0;
            div_rem <= 33'h0;
            div_den <= RST_STEP_DEN;
            div_neg <= 1'b0;
            DEMAND_POS_OUT <= 32'h0;
        end else begin
            case (div_state)
                CSSI_DIV_IDLE: begin
                    if (div_start) begin
                        div_dvd <= mag64(pos_total);
                        div_neg <= pos_total[63];
                        div_den <= step_den;
                        div_rem <= 33'h0;
                        div_cnt <= 7'h0;
                        div_state <= CSSI_DIV_RUN;
                    end
                end
                CSSI_DIV_RUN: begin
                    if (rem_shift >= {1'b0, div_den}) begin
                        div_rem <= rem_shift - {1'b0, div_den};
                        div_dvd <= {div_dvd[62:0], 1'b1};
                    end else begin
                        div_rem <= rem_shift;
                        div_dvd <= {div_dvd[62:0], 1'b0};
                    end
                    div_cnt <= div_cnt + 7'h1;
                    if (div_cnt == 7'(DIV_STEPS - 1)) begin
                        div_state <= CSSI_DIV_IDLE;
                    end
                end
                default: div_state <= CSSI_DIV_IDLE;
            endcase
            if (div_state == CSSI_DIV_RUN && div_cnt == 7'(DIV_STEPS - 1)) begin
                DEMAND_POS_OUT <= div_neg
                    ? 32'(-{div_dvd[30:0], (rem_shift >= {1'b0, div_den})})
                    : {div_dvd[30:0], (rem_shift >= {1'b0, div_den})};
            end
        end
    end

    // Electrical angle: one period spans four full steps
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            ELEC_ANGLE_OUT <= '0;
        end else begin
            ELEC_ANGLE_OUT <= DEMAND_POS_OUT[ANGLE_W-1:0];
        end
    end

    // Following error: outside the corridor for longer than the timeout
    assign pos_err = $signed({ACTUAL_POS_IN[31], ACTUAL_POS_IN})
        - $signed({DEMAND_POS_OUT[31], DEMAND_POS_OUT});

    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            fe_cnt <= 16'h0;
            ferr <= 1'b0;
        end else if (mode != CSSI_MODE_CLKDIR || !CLOSED_LOOP_IN) begin
            fe_cnt <= 16'h0;
            ferr <= 1'b0;
        end else if ((pos_err[32] ? 33'(-pos_err) : 33'(pos_err)) > {1'b0, fe_window}) begin
            if (ms_tick && fe_cnt != 16'hFFFF) begin
                fe_cnt <= fe_cnt + 16'h1;
            end
            ferr <= (fe_cnt > fe_timeout);
        end else begin
            fe_cnt <= 16'h0;
            ferr <= 1'b0;
        end
    end

    // Status word
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            STATUS_OUT <= 16'h0;
        end else begin
            STATUS_OUT <= 16'h0;
            if (mode == CSSI_MODE_CSV || mode == CSSI_MODE_CST) begin
                STATUS_OUT[SW_SYNC_BIT] <= in_sync;
                STATUS_OUT[SW_FOLLOW_BIT] <= follow;
            end else if (mode == CSSI_MODE_CLKDIR) begin
                STATUS_OUT[SW_FERR_BIT] <= ferr;
            end
        end
    end
endmodule
`default_nettype wire

// ===== cssi_top_test.sv
// Purpose: Self-checking bench of the setpoint block
// Assumes: Millisecond shortened to 10 core clocks
// Notes: Inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module cssi_top_test
    import cssi_pkg::*;
;
    logic clk, nrst, sync, cl, en, ack, err, tk, sclk, sdir;
    logic [31:0] apos, rdata, vel, dpos;
    logic [15:0] torq, stat;
    cssi_od_req_t req;
    int n_errors, tests_run;
    time t0;
    logic [7:0] codes[3] = '{8'h09, 8'h0A, 8'hFF};
    cssi_top #(.MS_CLKS(10)) cssi_top_inst (.CORE_CLK_IN(clk), .NRST_IN(nrst),
        .OD_REQ_IN(req), .OD_RDATA_OUT(rdata), .OD_ACK_OUT(ack), .OD_ERR_OUT(err),
        .STEP_CLK_IN(sclk), .STEP_DIR_IN(sdir), .FIELDBUS_SYNC_IN(sync),
        .CLOSED_LOOP_IN(cl), .OP_ENABLED_IN(en), .ACTUAL_POS_IN(apos),
        .CYCLE_TICK_OUT(tk), .VEL_CMD_OUT(vel), .TORQUE_CMD_OUT(torq),
        .DEMAND_POS_OUT(dpos), .ELEC_ANGLE_OUT(), .STATUS_OUT(stat));
    cssi_pulse_src cssi_pulse_src_inst (.clk_out(sclk), .dir_out(sdir));
    // Clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One object access; answer sampled after the taking edge
    task acc(input logic w, input logic [15:0] i, input logic [7:0] s,
        input logic [31:0] d, input logic e, input logic [31:0] r);
        @(negedge clk);
        req = '{w, !w, i, s, d};
        @(negedge clk);
        req = '0;
        chk("ack", ack, 32'h1);
        chk("err", err, e);
        if (!w) chk("rdata", rdata, r);
    endtask
    // Wait for the next cycle tick
    task tick;
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (tk !== 1'b1 && k < 5000);
        if (k >= 5000) n_errors++;
    endtask
    task wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task give_verdict;
        if (n_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #1000000;
        n_errors++;
        give_verdict;
    end
    // Main sequence
    initial begin
        {nrst, sync, cl, en} = 4'h0;
        req = '0;
        apos = '0;
        n_errors = 0;
        tests_run = 0;
        wt(8);
        nrst = 1'b1;
        acc(0, IDX_STEP_NUM, '0, '0, 0, 32'h80);
        acc(1, IDX_CYCLE, SUB_TIME_INDEX, 32'h03, 1, '0);
        acc(1, IDX_STEP_DEN, '0, '0, 1, '0);
        acc(1, IDX_STATUS, '0, '0, 1, '0);
        acc(1, 16'h1234, '0, '0, 1, '0);
        acc(0, IDX_CYCLE, SUB_TIME_INDEX, '0, 0, 32'hFD);
        acc(0, IDX_STEP_DEN, '0, '0, 0, 32'h1);
        foreach (codes[j]) begin
            acc(1, IDX_MODE, '0, {24'h0, codes[j]}, 0, '0);
            acc(0, IDX_MODE, '0, '0, 0, {24'h0, codes[j]});
        end
        // Period of two doubles the cycle
        acc(1, IDX_CYCLE, SUB_PERIOD, 32'h2, 0, '0);
        tick;
        tick;
        t0 = $time;
        tick;
        chk("period", 32'(($time - t0) / 20), 32'h14);
        acc(1, IDX_CYCLE, SUB_PERIOD, 32'h1, 0, '0);
        // Velocity mode with sync
        en = 1'b1;
        acc(1, IDX_MODE, '0, 32'h9, 0, '0);
        acc(1, IDX_TGT_VEL, '0, 32'h64, 0, '0);
        tick;
        chk("vel", vel, 32'h64);
        chk("follow", stat[12], 32'h1);
        sync = 1'b1;
        wt(1);
        sync = 1'b0;
        tick;
        wt(1);
        chk("sync", stat[8], 32'h1);
        tick;
        wt(1);
        chk("nosync", stat[8], 32'h0);
        // Torque mode clamp
        cl = 1'b1;
        acc(1, IDX_MODE, '0, 32'hA, 0, '0);
        acc(1, IDX_MAX_CURRENT, '0, 32'h200, 0, '0);
        acc(1, IDX_TGT_TORQUE, '0, 32'h7000, 0, '0);
        tick;
        chk("tq_pos", torq, 32'h200);
        chk("vel_off", vel, 32'h0);
        acc(1, IDX_TGT_TORQUE, '0, 32'h9000, 0, '0);
        tick;
        chk("tq_neg", torq, 32'hFE00);
        cl = 1'b0;
        tick;
        chk("tq_open", torq, 32'h0);
        chk("nofollow", stat[12], 32'h0);
        // Step input accumulation and scaling
        acc(1, IDX_MODE, '0, 32'hFF, 0, '0);
        cssi_pulse_src_inst.send(4, 1'b1);
        wt(200);
        chk("pos_fwd", dpos, 32'h200);
        acc(1, IDX_STEP_NUM, '0, 32'h3, 0, '0);
        acc(1, IDX_STEP_DEN, '0, 32'h2, 0, '0);
        cssi_pulse_src_inst.send(5, 1'b0);
        wt(200);
        chk("pos_rev", dpos, 32'hF8);
        // Following error after the timeout
        cl = 1'b1;
        apos = 32'h0001_0000;
        wt(50);
        chk("fe_early", stat[13], 32'h0);
        wt(150);
        chk("fe_set", stat[13], 32'h1);
        apos = 32'hF8;
        wt(3);
        chk("fe_clr", stat[13], 32'h0);
        give_verdict;
    end
endmodule
`default_nettype wire
